// ---- nvmps_pkg.sv ----
// constants and types of the nvm protection, status and command block
package nvmps_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] A_PROT = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CMD  = 8'h08;
  localparam logic [7:0] A_ADDR = 8'h0C;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam logic [7:0] A_IST  = 8'h14;
  localparam logic [7:0] A_ICLR = 8'h18;
  localparam logic [7:0] A_IEN  = 8'h1C;
  localparam logic [7:0] A_SEC  = 8'h20;
  // status register bit positions
  localparam int B_CBE = 7;
  localparam int B_CCF = 6;
  localparam int B_PV  = 5;
  localparam int B_AE  = 4;
  localparam int B_BL  = 2;
  // control register bit positions
  localparam int C_DIV  = 0;
  localparam int C_STOP = 1;
  // interrupt status bit positions
  localparam int I_CC = 0;
  localparam int I_PV = 1;
  localparam int I_AE = 2;
  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE  = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_SERA  = 8'h40;
  localparam logic [7:0] CMD_MASS  = 8'h41;
  localparam logic [7:0] CMD_ABORT = 8'h47;
  // protection field codes and limits
  localparam logic [4:0]  FPS_NONE  = 5'h1F;
  localparam logic [4:0]  FPS_A0    = 5'h17;
  localparam logic [4:0]  FPS_4K    = 5'h10;
  localparam logic [4:0]  FPS_2K    = 5'h0F;
  localparam logic [16:0] TOP_A     = 17'h1_0000;
  localparam logic [16:0] MID_A1    = 17'h0_8000;
  localparam logic [16:0] EE_LIM2   = 17'h0_3FF0;
  localparam logic [16:0] EE_LIM1   = 17'h0_3FE0;
  localparam logic [16:0] EE_LIM0   = 17'h0_3FC0;
  localparam logic [5:0]  FRANK_ALL = 6'h20;
  // command run length and security codes
  localparam logic [1:0] SEC_UNSEC = 2'b10;
  localparam logic [3:0] RUN_CYC   = 4'h8;
  // command engine states
  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} nvmps_state_t;
endpackage

// ---- nvmps_top.sv ----
// protection, status and command register block of the nvm controller
//
// How it works
// - reset loads nonvolatile image into protection
// - protection readable; writes only grow protection
// - mass erase refused if anything protected
// - eeprom field protects top eeprom bytes
// - open bit clear means all flash protected
// - flash field protects array tops stepwise
// - buffer-empty: write one launches, clears flag
// - only burst program may be queued
// - complete flag follows idle engine, ignores writes
// - protected target: ignore, set violation flag
// - access error cases; write one clears
// - blank flag set on erased blank check
// - six legal command codes
// - other codes raise access error
// - erased flash or backdoor unsecures part
module nvmps_top
  import nvmps_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // nonvolatile images and array status
  input  wire logic [7:0]  nonvolatile_protection_image_i,
  input  wire logic [1:0]  nonvolatile_security_i,
  input  wire logic        array_blank_i,
  input  wire logic        backdoor_key_ok_i,
  // outputs
  output logic [1:0]       security_state_code_o,
  output logic             irq_o
);
  import nvmps_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]   protection_register; // eeprom, flash select, open
  logic [7:0]   command_register;    // latched command code
  logic [17:0]  target_addr;         // bit 17 picks eeprom
  logic         divider_ready;       // clock divider initialised
  logic         cbe;                 // command buffer empty
  logic         ccf;                 // command complete
  logic         pviol;               // protection violation
  logic         accerr;              // access error
  logic         blank;               // blank verified
  logic [2:0]   irq_stat;            // sticky events
  logic [2:0]   irq_en;              // event enables
  logic [1:0]   sec;                 // security state code
  nvmps_state_t state;               // engine state
  logic [3:0]   cnt;                 // cycles left on running command
  logic [7:0]   run_cmd;             // command in the array
  logic [17:0]  run_addr;            // its target
  logic         pend;                // a burst waits in the buffer
  logic [17:0]  pend_addr;           // waiting burst target
  // bus data phase
  logic         dp_wr;
  logic         dp_rd;
  logic [7:0]   dp_addr;

  //////////////////////////////////////////////////////////////////////
  // protection decode
  function automatic logic prot_hit(input logic [7:0] p, input logic [17:0] a);
    logic [4:0]  flash_protect_select;
    logic [4:0]  k;
    logic [16:0] lim;
    logic        hit;
    flash_protect_select = p[5:1];
    k   = 5'h00;
    lim = TOP_A;
    hit = 1'b0;
    if (a[17]) begin
      // eeprom: lower field value guards more of the top
      unique case (p[7:6])
        2'd2:    lim = EE_LIM2;
        2'd1:    lim = EE_LIM1;
        2'd0:    lim = EE_LIM0;
        default: lim = TOP_A;
      endcase
      hit = {3'b000, a[13:0]} >= lim;
    end else if (!p[0]) begin
      hit = 1'b1;
    end else if (flash_protect_select >= FPS_A0) begin
      // 8k steps down from the top of array 0
      k   = FPS_NONE - flash_protect_select;
      lim = TOP_A - {k[3:0], 13'h0000};
      hit = !a[16] && ({1'b0, a[15:0]} >= lim);
    end else if (flash_protect_select >= FPS_4K) begin
      // array 0 whole, array 1 in 4k steps
      k   = FPS_A0 - flash_protect_select;
      lim = TOP_A - {1'b0, k[3:0], 12'h000};
      hit = !a[16] || ({1'b0, a[15:0]} >= lim);
    end else begin
      // array 1 in 2k steps below its middle
      k   = FPS_2K - flash_protect_select;
      lim = MID_A1 - {2'b00, k[3:0], 11'h000};
      hit = !a[16] || ({1'b0, a[15:0]} >= lim);
    end
    return hit;
  endfunction

  // flash rank: larger means more protected
  function automatic logic [5:0] frank(input logic [7:0] p);
    return p[0] ? {1'b0, FPS_NONE - p[5:1]} : FRANK_ALL;
  endfunction

  // any eeprom or flash protection at all blocks mass erase
  logic any_prot;
  assign any_prot = (protection_register[7:6] != 2'd3) || !protection_register[0]
                    || (protection_register[5:1] != FPS_NONE);

  //////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes have no wait state, reads one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dp_wr       <= 1'b0;
      dp_rd       <= 1'b0;
      dp_addr     <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hresp_o <= 1'b0; // always okay
      if (hready_i && hsel_i && htrans_i[1]) begin
        dp_wr       <= hwrite_i;
        dp_rd       <= !hwrite_i;
        dp_addr     <= haddr_i[7:0];
        hreadyout_o <= hwrite_i;
      end else begin
        dp_wr       <= 1'b0;
        dp_rd       <= 1'b0;
        hreadyout_o <= 1'b1;
      end
    end
  end

  logic wr;
  assign wr = dp_wr && hreadyout_o;

  // read data registered during the wait state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (dp_rd && !hreadyout_o) begin
      unique case (dp_addr)
        A_PROT:  hrdata_o <= {24'h00_0000, protection_register};
        A_STAT:  hrdata_o <= {24'h00_0000, cbe, ccf, pviol, accerr,
                              1'b0, blank, 2'b00};
        A_CMD:   hrdata_o <= {24'h00_0000, command_register};
        A_ADDR:  hrdata_o <= {14'h0000, target_addr};
        A_CTRL:  hrdata_o <= {31'h0000_0000, divider_ready};
        A_IST:   hrdata_o <= {29'h0000_0000, irq_stat};
        A_IEN:   hrdata_o <= {29'h0000_0000, irq_en};
        A_SEC:   hrdata_o <= {30'h0000_0000, sec};
        default: hrdata_o <= 32'h0000_0000; // unmapped and clear reg
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // protection register: image at reset, then grow-only
  logic [7:0] wp;
  assign wp = hwdata_i[7:0];
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      protection_register <= nonvolatile_protection_image_i;
    end else if (wr && dp_addr == A_PROT && wp[7:6] <= protection_register[7:6]
                 && frank(wp) >= frank(protection_register)) begin
      protection_register <= wp;
    end
  end

  // plain software registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      command_register <= 8'h00;
      target_addr      <= 18'h0_0000;
      divider_ready    <= 1'b0;
      irq_en           <= 3'b000;
    end else if (wr) begin
      if (dp_addr == A_CMD)  command_register <= hwdata_i[7:0];
      if (dp_addr == A_ADDR) target_addr      <= hwdata_i[17:0];
      if (dp_addr == A_CTRL) divider_ready    <= hwdata_i[C_DIV];
      if (dp_addr == A_IEN)  irq_en           <= hwdata_i[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // launch decode
  logic launch;   // write of one to the empty flag
  logic legal;    // code is one of six
  logic progera;  // program, erase or abort code
  logic busy_ok;  // queueing allowed now
  logic seq_err;  // sequence or divider fault
  logic prot_err; // target protected
  logic go;       // command accepted
  logic stop_hit; // stop entered with work in flight
  always_comb begin
    launch  = wr && dp_addr == A_STAT && hwdata_i[B_CBE] && cbe;
    legal   = command_register inside {CMD_BLANK, CMD_BYTE, CMD_BURST,
                                       CMD_SERA, CMD_MASS, CMD_ABORT};
    progera = legal && command_register != CMD_BLANK;
    busy_ok = state == ST_IDLE
              || (command_register == CMD_BURST && run_cmd == CMD_BURST);
    seq_err = !legal || (progera && !divider_ready) || !busy_ok
              || pviol || accerr;
    prot_err = progera && command_register != CMD_ABORT
               && (command_register == CMD_MASS ? any_prot
                   : prot_hit(protection_register, target_addr));
    go       = launch && !seq_err && !prot_err;
    stop_hit = wr && dp_addr == A_CTRL && hwdata_i[C_STOP]
               && (state == ST_RUN || pend);
  end

  //////////////////////////////////////////////////////////////////////
  // command engine with one burst buffer slot
  logic done;
  assign done = state == ST_RUN && cnt == 4'h1;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state     <= ST_IDLE;
      cnt       <= 4'h0;
      run_cmd   <= 8'h00;
      run_addr  <= 18'h0_0000;
      pend      <= 1'b0;
      pend_addr <= 18'h0_0000;
      cbe       <= 1'b1;
    end else if (stop_hit) begin
      // stop cancels everything in flight
      state <= ST_IDLE;
      pend  <= 1'b0;
      cbe   <= 1'b1;
    end else if (go && state == ST_IDLE) begin
      state    <= ST_RUN;
      cnt      <= RUN_CYC;
      run_cmd  <= command_register;
      run_addr <= target_addr;
      cbe      <= 1'b0;
    end else if (go) begin
      pend      <= 1'b1;
      pend_addr <= target_addr;
      cbe       <= 1'b0;
    end else if (done && pend) begin
      cnt      <= RUN_CYC;
      run_addr <= pend_addr;
      pend     <= 1'b0;
      cbe      <= 1'b1;
    end else if (done) begin
      state <= ST_IDLE;
      cbe   <= 1'b1;
    end else begin
      if (state == ST_RUN) cnt <= cnt - 4'h1;
      // a burst leaves the buffer as it enters the array
      if (state == ST_RUN && run_cmd == CMD_BURST && !pend && !cbe)
        cbe <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status flags; set beats clear
  logic done_last; // completion of the final command
  assign done_last = done && !pend && !stop_hit && !go; // a burst queued now keeps it busy
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ccf    <= 1'b1;
      pviol  <= 1'b0;
      accerr <= 1'b0;
      blank  <= 1'b0;
    end else begin
      if (go) ccf <= 1'b0;
      else if (done_last || stop_hit) ccf <= 1'b1;
      if (launch && !seq_err && prot_err) pviol <= 1'b1;
      else if (wr && dp_addr == A_STAT && hwdata_i[B_PV]) pviol <= 1'b0;
      if ((launch && seq_err) || stop_hit) accerr <= 1'b1;
      else if (wr && dp_addr == A_STAT && hwdata_i[B_AE]) accerr <= 1'b0;
      if (done_last && run_cmd == CMD_BLANK && array_blank_i) blank <= 1'b1;
      else if (go) blank <= 1'b0;
    end
  end

  // security state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sec <= nonvolatile_security_i;
    end else if (backdoor_key_ok_i || (done_last && run_cmd == CMD_BLANK
                 && !run_addr[17] && array_blank_i)) begin
      sec <= SEC_UNSEC;
    end
  end
  assign security_state_code_o = sec;

  //////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, write-one clear
  logic [2:0] ev;
  assign ev = {(launch && seq_err) || stop_hit,
               launch && !seq_err && prot_err, done_last};
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_stat <= 3'b000;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && dp_addr == A_ICLR) ? hwdata_i[2:0]
                                : 3'b000)) | ev;
      irq_o    <= |(irq_stat & irq_en);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_launch_bad;
    launch && seq_err;
  endsequence
  sequence s_launch_ok;
    go;
  endsequence
  AST_PROT_GROW: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(protection_register) |-> frank(protection_register)
      >= frank($past(protection_register))) else $error("protection shrank");
  AST_MASS_REFUSE: assert property (@(posedge clk_i) disable iff (reset_i)
    launch && command_register == CMD_MASS && protection_register != {2'b11, FPS_NONE, 1'b1}
      |=> !$rose(state == ST_RUN) && !$rose(pend)) else $error("mass erase ran while protected");
  AST_LAUNCH_CBE: assert property (@(posedge clk_i) disable iff (reset_i)
    s_launch_ok and (state == ST_IDLE) |=> !cbe ##0 state == ST_RUN)
    else $error("launch did not start engine");
  AST_NO_QUEUE: assert property (@(posedge clk_i) disable iff (reset_i)
    pend |-> run_cmd == CMD_BURST) else $error("non-burst queued");
  AST_CCF: assert property (@(posedge clk_i) disable iff (reset_i)
    s_launch_ok |=> !ccf ##[1:32] ccf) else $error("complete flag wrong");
  AST_PVIOL: assert property (@(posedge clk_i) disable iff (reset_i)
    launch && !seq_err && prot_err |=> pviol && !$rose(state == ST_RUN) && !$rose(pend))
    else $error("protected command not refused");
  AST_ACCERR: assert property (@(posedge clk_i) disable iff (reset_i)
    s_launch_bad |=> accerr) else $error("access error not raised");
  AST_STAT_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    dp_rd && dp_addr == A_STAT ##1 hreadyout_o |-> hrdata_o[3] == 1'b0
      && hrdata_o[1:0] == 2'b00) else $error("reserved status bits set");
endmodule // nvmps_top

// ---- nvmps_tb.sv ----
// self-checking bench of the nvm protection, status and command block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvmps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // clock, reset and design ports
  logic        clk_i     = 1'b0;   // 100 MHz bus clock
  logic        reset_i   = 1'b1;   // synchronous, active high
  logic        hsel_i    = 1'b0;   // slave select
  logic [31:0] haddr_i   = '0;     // byte address
  logic [1:0]  htrans_i  = 2'b00;  // idle until a transfer starts
  logic        hwrite_i  = 1'b0;   // direction
  logic [2:0]  hsize_i   = 3'b010; // always a whole word
  logic [31:0] hwdata_i  = '0;     // write data
  logic        hready_i;           // loop back of the single slave
  logic [31:0] hrdata_o;           // read data
  logic        hreadyout_o;        // slave ready
  logic        hresp_o;            // response, always okay
  logic [7:0]  prot_img  = 8'hFF;  // image with nothing protected
  logic [1:0]  sec_img   = 2'b00;  // secured part at reset
  logic        blank_i   = 1'b1;   // array reads erased
  logic        key_ok_i  = 1'b0;   // backdoor key pulse
  logic [1:0]  sec_o;              // security state
  logic        irq_o;              // level interrupt
  int          num_errors = 0;     // mismatches seen
  int          n_compared = 0;     // comparisons made
  logic [31:0] q;                  // last read value

  assign hready_i = hreadyout_o;   // one slave: its ready is the bus ready
  always #5 clk_i = ~clk_i;

  nvmps_top nvmps_top_i (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .nonvolatile_protection_image_i(prot_img), .nonvolatile_security_i(sec_img),
    .array_blank_i(blank_i), .backdoor_key_ok_i(key_ok_i),
    .security_state_code_o(sec_o), .irq_o(irq_o));

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite single transfers; the wait is open, only the watchdog ends it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= {24'h00_0000, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
    hsel_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  // code, target, then the launch write
  task automatic launch(input logic [7:0] code, input logic [17:0] ad);
    wr(A_CMD, {24'h00_0000, code});
    wr(A_ADDR, {14'h0000, ad});
    wr(A_STAT, 32'h0000_0080);
  endtask

  // poll until the complete flag is back, then compare the whole status
  task automatic done(input string nm, input logic [7:0] exp);
    for (int i = 0; i < 40; i++) begin
      rd(A_STAT);
      if (q[B_CCF] === 1'b1) break;
    end
    chk(nm, q, {24'h00_0000, exp});
  endtask

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far above the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // tests
  logic [7:0] codes [6] = '{CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_SERA, CMD_MASS, CMD_ABORT};
  logic [7:0] busy  [6] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0] fin   [6] = '{8'hC4, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0};

  initial begin
    do_reset();
    rd(A_PROT); chk("prot_reset", q, 32'h0000_00FF);
    chk("hresp_okay", {31'h0, hresp_o}, 32'h0000_0000);
    rd(A_STAT); chk("stat_reset", q, 32'h0000_00C0);
    chk("sec_reset", {30'h0, sec_o}, {30'h0, sec_img});
    @(posedge clk_i) key_ok_i <= 1'b1;
    @(posedge clk_i) key_ok_i <= 1'b0;
    rd(A_SEC); chk("sec_key", q, {30'h0, SEC_UNSEC});
    do_reset();
    chk("sec_again", {30'h0, sec_o}, 32'h0000_0000);
    // unused status bits and an unmapped place
    wr(A_STAT, 32'h0000_000F);
    rd(A_STAT); chk("stat_unused", q, 32'h0000_00C0);
    rd(8'h40); chk("unmapped", q, 32'h0000_0000);
    // program before the divider is set, then interrupt raise, mask, clear
    launch(CMD_BYTE, 18'h0_0100);
    rd(A_STAT); chk("no_div", q, 32'h0000_00D0);
    wr(A_STAT, 32'h0000_0000);
    rd(A_STAT); chk("w0_keeps", q, 32'h0000_00D0);
    wr(A_IEN, 32'h0000_0004);
    rd(A_IST); chk("ist_ae", {31'h0, q[I_AE]}, 32'h0000_0001);
    chk("irq_on", {31'h0, irq_o}, 32'h0000_0001);
    wr(A_IEN, 32'h0000_0000);
    rd(A_IST); chk("irq_mask", {31'h0, irq_o}, 32'h0000_0000);
    wr(A_IEN, 32'h0000_0004);
    wr(A_ICLR, 32'h0000_0007);
    wr(A_STAT, 32'h0000_0010);
    rd(A_STAT); chk("ae_clr", q, 32'h0000_00C0);
    chk("irq_clr", {31'h0, irq_o}, 32'h0000_0000);
    wr(A_IEN, 32'h0000_0000);
    // illegal code with the divider ready
    wr(A_CTRL, 32'h0000_0001);
    launch(8'h13, 18'h0_0100);
    rd(A_STAT); chk("illegal", q, 32'h0000_00D0);
    wr(A_STAT, 32'h0000_0010);
    // every legal code, nothing protected
    foreach (codes[i]) begin
      launch(codes[i], 18'h0_0100);
      rd(A_STAT);
      if (codes[i] != CMD_ABORT) chk("busy", q, {24'h0, busy[i]});
      done("legal", fin[i]);
      if (i == 0) chk("sec_blank", {30'h0, sec_o}, {30'h0, SEC_UNSEC});
    end
    // a blank check over a written array leaves the flag clear
    blank_i <= 1'b0;
    launch(CMD_BLANK, 18'h0_0100);
    done("not_blank", 8'hC0);
    blank_i <= 1'b1;
    // a non-burst launched behind a running burst is refused
    launch(CMD_BURST, 18'h0_0100);
    wr(A_CMD, {24'h00_0000, CMD_BYTE});
    wr(A_STAT, 32'h0000_0080);
    done("busy_refuse", 8'hD0);
    wr(A_STAT, 32'h0000_0010);
    // a second burst queued behind the first
    launch(CMD_BURST, 18'h0_0200);
    wr(A_STAT, 32'h0000_0080);
    rd(A_STAT); chk("queued", q, 32'h0000_0000);
    done("burst_pair", 8'hC0);
    // stop entry while a command runs
    launch(CMD_SERA, 18'h0_0100);
    wr(A_CTRL, 32'h0000_0003);
    done("stop", 8'hD0);
    wr(A_STAT, 32'h0000_0010);
    // protection grows, never shrinks
    wr(A_PROT, 32'h0000_00BD);
    rd(A_PROT); chk("grow", q, 32'h0000_00BD);
    wr(A_PROT, 32'h0000_00FF);
    rd(A_PROT); chk("shrink", q, 32'h0000_00BD);
    launch(CMD_BYTE, 18'h2_3FF5);
    done("ee_prot", 8'hE0);
    wr(A_STAT, 32'h0000_0020);
    rd(A_STAT); chk("pv_clr", q, 32'h0000_00C0);
    launch(CMD_BYTE, 18'h2_3FE5);
    done("ee_free", 8'hC0);
    launch(CMD_SERA, 18'h0_F000);
    done("fl_prot", 8'hE0);
    wr(A_STAT, 32'h0000_0020);
    launch(CMD_MASS, 18'h0_0000);
    done("mass", 8'hE0);
    wr(A_STAT, 32'h0000_0020);
    wr(A_PROT, 32'h0000_002F);
    launch(CMD_BYTE, 18'h1_F000);
    done("a1_free", 8'hC0);
    launch(CMD_BYTE, 18'h0_0010);
    done("a0_full", 8'hE0);
    wr(A_STAT, 32'h0000_0020);
    // array 1 in 4k and then 2k steps
    wr(A_PROT, 32'h0000_002D);
    launch(CMD_BYTE, 18'h1_EFFF);
    done("a1_4k_free", 8'hC0);
    launch(CMD_BYTE, 18'h1_F000);
    done("a1_4k_prot", 8'hE0);
    wr(A_STAT, 32'h0000_0020);
    wr(A_PROT, 32'h0000_001D);
    launch(CMD_BYTE, 18'h1_77FF);
    done("a1_2k_free", 8'hC0);
    launch(CMD_BYTE, 18'h1_7800);
    done("a1_2k_prot", 8'hE0);
    wr(A_STAT, 32'h0000_0020);
    wr(A_PROT, 32'h0000_002E);
    launch(CMD_BYTE, 18'h1_0000);
    done("closed", 8'hE0);
    final_report();
  end
endmodule // tb
